// file: design/led_dim_params.svh
`ifndef LED_DIM_PARAMS_SVH
`define LED_DIM_PARAMS_SVH

// register indices; the byte address is four times the index
`define IDX_PWM_CFG          10'h002
`define IDX_GROUP_A_MEMBERS  10'h003
`define IDX_GROUP_B_MEMBERS  10'h004
`define IDX_DRIVER5_PHASE    10'h017
`define IDX_GROUP_BROADCAST  10'h018
`define IDX_DRIVERS_0_TO_2   10'h019

// field positions
`define PHASE_MSB            7
`define PHASE_LSB            0
`define GRP_CODE_MSB         2
`define GRP_CODE_LSB         0
`define GRP_SEL_MSB          5
`define GRP_SEL_LSB          4
`define GRP_SEL_A_BIT        0
`define GRP_SEL_B_BIT        1
`define DRV2_MSB             10
`define DRV2_LSB             8
`define DRV1_MSB             6
`define DRV1_LSB             4
`define DRV0_MSB             2
`define DRV0_LSB             0
`define PERLEN_MSB           3
`define PERLEN_LSB           2
`define MEMBERS_MSB          2
`define MEMBERS_LSB          0

// reset values
`define PHASE5_RESET         16'h0213
`define GRP_SEL_RESET        2'h1
`define PER_CODE_RESET       3'h0
`define PERLEN_RESET         2'h0
`define MEMBERS_RESET        3'h0

// timing
`define PWM_PERIOD_CYCLES    8192
`define LAST_DOUBLING_CODE   3'h5
`define MAX_UPDATE_N_M1      5'h1F

`endif

// file: design/led_dim_pkg.sv
package led_dim_pkg;

    // apb slave phase, one-hot
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_SETUP  = 3'b010,
        ST_ACCESS = 3'b100
    } apb_state_t;

    // the three driver period codes in combined register order, packed without its spacer bits
    typedef struct packed {
        logic [2:0] drv2;
        logic [2:0] drv1;
        logic [2:0] drv0;
    } period_set_t;

    // group broadcast register contents
    typedef struct packed {
        logic [1:0] sel;
        logic [2:0] code;
    } group_bcast_t;

    // update interval minus one for a period code; codes above 5 saturate at 32
    function automatic logic [4:0] code_to_nm1(input logic [2:0] code);
        logic [5:0] n;
        n = 6'h01;
        if (code > 3'h5) begin
            n = 6'h20;
        end else begin
            n = 6'(6'h01 << code);
        end
        return 5'(n - 6'h01);
    endfunction

endpackage

// file: design/pwm_period_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "led_dim_params.svh"

module pwm_period_timer #(
    parameter int PERIOD_CYCLES = `PWM_PERIOD_CYCLES
) (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // period length selection
    input  wire logic [1:0] period_len,
    // one pulse per pwm period
    output logic            period_tick
);

    logic [13:0] cnt;
    logic [13:0] next_cnt;
    logic        next_tick;
    logic [13:0] limit;

    // period shortened by halving per length code step
    always_comb begin
        limit     = 14'((PERIOD_CYCLES >> period_len) - 1);
        next_cnt  = cnt + 14'h0001;
        next_tick = 1'b0;
        if (cnt >= limit) begin
            next_cnt  = 14'h0000;
            next_tick = 1'b1;
        end
    end

    // counter and tick registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt         <= 14'h0000;
            period_tick <= 1'b0;
        end else begin
            cnt         <= next_cnt;
            period_tick <= next_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cycles since the last tick
    logic [13:0] gap;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap <= 14'h0000;
        end else begin
            gap <= period_tick ? 14'h0001 : gap + 14'h0001;
        end
    end

    // spacing only regular once a whole period ran at one length
    logic [1:0] last_len;
    logic       settled;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_len <= 2'h0;
            settled  <= 1'b0;
        end else begin
            last_len <= period_len;
            if (period_len != last_len) begin
                settled <= 1'b0;
            end else if (period_tick) begin
                settled <= 1'b1;
            end
        end
    end

    AST_TICK_SPACING: assert property (@(posedge pclk) disable iff (!presetn)
        period_tick && settled && period_len == last_len |-> gap == limit + 14'h0001)
        else $error("tick spacing broken");

    AST_TICK_ONE_CYCLE: assert property (@(posedge pclk) disable iff (!presetn)
        period_tick && limit > 14'h0008 |=> !period_tick [*7])
        else $error("period tick too close");

endmodule // pwm_period_timer

`default_nettype wire

// file: design/dim_update_pacer.sv
`timescale 1ns/10ps
`default_nettype none
`include "led_dim_params.svh"

module dim_update_pacer (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // period tick and this driver's period code
    input  wire logic       period_tick,
    input  wire logic [2:0] code,
    // duty update strobe
    output logic            duty_update
);

    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic       next_update;
    logic [4:0] nm1;

    always_comb begin
        nm1         = led_dim_pkg::code_to_nm1(code);
        next_cnt    = cnt;
        next_update = 1'b0;
        if (period_tick) begin
            if (cnt >= nm1) begin
                next_cnt    = 5'h00;
                next_update = 1'b1;
            end else begin
                next_cnt = cnt + 5'h01;
            end
        end
    end

    // period counter and strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt         <= 5'h00;
            duty_update <= 1'b0;
        end else begin
            cnt         <= next_cnt;
            duty_update <= next_update;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strobe follows a tick
    AST_UPDATE_ON_TICK: assert property (@(posedge pclk) disable iff (!presetn)
        duty_update |-> $past(period_tick) && $past(cnt) == $past(nm1)
            || $past(period_tick) && $past(cnt) > $past(nm1))
        else $error("update without completed interval");

endmodule // dim_update_pacer

`default_nettype wire

// file: design/led_dim_period_phase_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "led_dim_params.svh"

// Function
// - driver 5 phase offset, 8 bits read/write, loads 0x13, the low 8 bits of the printed 0x213, at reset
// - group register write copies its period code to every member driver of the selected groups
// - select bit 0 picks group A, bit 1 group B, both allowed, reset 1
// - group write with zero select is dropped; driver periods unchanged
// - duty updates once every 1,2,4,8,16,32 periods; codes 6,7 give 32
// - pwm period 8192 cycles by default, length set by config bits 3:2
// - combined register holds driver 2, 1, 0 period codes, each reset zero
module led_dim_period_phase_regs #(
    parameter int PERIOD_CYCLES = `PWM_PERIOD_CYCLES
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // settings toward the pwm channels
    output logic [7:0]       phase_offset_value,
    output led_dim_pkg::period_set_t drivers_0_to_2_period,
    output logic [1:0]       pwm_period_len,
    // duty update strobes, one per driver
    output logic [2:0]       duty_update
);

    ////////////////////////////////////////////////////////////////////////
    // register state
    led_dim_pkg::apb_state_t   state;
    led_dim_pkg::apb_state_t   next_state;
    led_dim_pkg::group_bcast_t group_period_broadcast;
    led_dim_pkg::group_bcast_t next_bcast;
    led_dim_pkg::period_set_t  next_periods;
    logic [7:0]                next_phase;
    logic [1:0]                next_perlen;
    logic [2:0]                group_a_membership;
    logic [2:0]                next_grpa;
    logic [2:0]                group_b_membership;
    logic [2:0]                next_grpb;
    logic [31:0]               next_prdata;
    logic                      next_err;
    logic                      err;
    logic [9:0]                idx;
    logic                      setup_cyc;
    logic                      wr_take;
    logic [2:0]                members;
    logic [2:0]                code_vec [3];

    assign idx       = paddr[11:2];
    assign setup_cyc = psel && !penable;
    assign wr_take   = psel && penable && pwrite;

    function automatic logic is_mapped(input logic [9:0] a);
        return a == `IDX_PWM_CFG || a == `IDX_GROUP_A_MEMBERS
            || a == `IDX_GROUP_B_MEMBERS || a == `IDX_DRIVER5_PHASE
            || a == `IDX_GROUP_BROADCAST || a == `IDX_DRIVERS_0_TO_2;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // apb phase tracking
    always_comb begin
        case (state)
            led_dim_pkg::ST_IDLE:   next_state = setup_cyc ? led_dim_pkg::ST_SETUP
                                                           : led_dim_pkg::ST_IDLE;
            led_dim_pkg::ST_SETUP:  next_state = led_dim_pkg::ST_ACCESS;
            led_dim_pkg::ST_ACCESS: next_state = setup_cyc ? led_dim_pkg::ST_SETUP
                                                           : led_dim_pkg::ST_IDLE;
            default:                next_state = led_dim_pkg::ST_IDLE;
        endcase
    end

    // zero wait state; error flagged for unmapped index
    assign pready  = 1'b1;
    assign pslverr = psel && penable && err;

    // read data and error captured in the setup cycle
    always_comb begin
        next_prdata = prdata;
        next_err    = err;
        if (setup_cyc) begin
            next_err    = !is_mapped(idx);
            next_prdata = 32'h0000_0000;
            case (idx)
                `IDX_PWM_CFG:
                    next_prdata[`PERLEN_MSB:`PERLEN_LSB] = pwm_period_len;
                `IDX_GROUP_A_MEMBERS:
                    next_prdata[`MEMBERS_MSB:`MEMBERS_LSB] = group_a_membership;
                `IDX_GROUP_B_MEMBERS:
                    next_prdata[`MEMBERS_MSB:`MEMBERS_LSB] = group_b_membership;
                `IDX_DRIVER5_PHASE:
                    next_prdata[`PHASE_MSB:`PHASE_LSB] = phase_offset_value;
                `IDX_GROUP_BROADCAST: begin
                    next_prdata[`GRP_SEL_MSB:`GRP_SEL_LSB]   = group_period_broadcast.sel;
                    next_prdata[`GRP_CODE_MSB:`GRP_CODE_LSB] = group_period_broadcast.code;
                end
                `IDX_DRIVERS_0_TO_2: begin
                    next_prdata[`DRV2_MSB:`DRV2_LSB] = drivers_0_to_2_period.drv2;
                    next_prdata[`DRV1_MSB:`DRV1_LSB] = drivers_0_to_2_period.drv1;
                    next_prdata[`DRV0_MSB:`DRV0_LSB] = drivers_0_to_2_period.drv0;
                end
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // group member mask
    assign members = (pwdata[`GRP_SEL_LSB + `GRP_SEL_A_BIT] ? group_a_membership : 3'h0)
                   | (pwdata[`GRP_SEL_LSB + `GRP_SEL_B_BIT] ? group_b_membership : 3'h0);

    // register writes and group broadcast
    always_comb begin
        next_phase   = phase_offset_value;
        next_bcast   = group_period_broadcast;
        next_periods = drivers_0_to_2_period;
        next_perlen  = pwm_period_len;
        next_grpa    = group_a_membership;
        next_grpb    = group_b_membership;
        if (wr_take) begin
            case (idx)
                `IDX_PWM_CFG:
                    next_perlen = pwdata[`PERLEN_MSB:`PERLEN_LSB];
                `IDX_GROUP_A_MEMBERS:
                    next_grpa = pwdata[`MEMBERS_MSB:`MEMBERS_LSB];
                `IDX_GROUP_B_MEMBERS:
                    next_grpb = pwdata[`MEMBERS_MSB:`MEMBERS_LSB];
                `IDX_DRIVER5_PHASE:
                    next_phase = pwdata[`PHASE_MSB:`PHASE_LSB];
                `IDX_GROUP_BROADCAST: begin
                    if (pwdata[`GRP_SEL_MSB:`GRP_SEL_LSB] != 2'h0) begin
                        next_bcast.sel  = pwdata[`GRP_SEL_MSB:`GRP_SEL_LSB];
                        next_bcast.code = pwdata[`GRP_CODE_MSB:`GRP_CODE_LSB];
                    end
                end
                `IDX_DRIVERS_0_TO_2: begin
                    next_periods.drv2 = pwdata[`DRV2_MSB:`DRV2_LSB];
                    next_periods.drv1 = pwdata[`DRV1_MSB:`DRV1_LSB];
                    next_periods.drv0 = pwdata[`DRV0_MSB:`DRV0_LSB];
                end
                default: next_phase = phase_offset_value;
            endcase
            if (idx == `IDX_GROUP_BROADCAST
                && pwdata[`GRP_SEL_MSB:`GRP_SEL_LSB] != 2'h0) begin
                if (members[0]) next_periods.drv0 = pwdata[`GRP_CODE_MSB:`GRP_CODE_LSB];
                if (members[1]) next_periods.drv1 = pwdata[`GRP_CODE_MSB:`GRP_CODE_LSB];
                if (members[2]) next_periods.drv2 = pwdata[`GRP_CODE_MSB:`GRP_CODE_LSB];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                  <= led_dim_pkg::ST_IDLE;
            prdata                 <= 32'h0000_0000;
            err                    <= 1'b0;
            phase_offset_value     <= 8'(`PHASE5_RESET);
            group_period_broadcast <= '{sel: `GRP_SEL_RESET, code: `PER_CODE_RESET};
            drivers_0_to_2_period  <= '{drv2: `PER_CODE_RESET, drv1: `PER_CODE_RESET,
                                        drv0: `PER_CODE_RESET};
            pwm_period_len         <= `PERLEN_RESET;
            group_a_membership     <= `MEMBERS_RESET;
            group_b_membership     <= `MEMBERS_RESET;
        end else begin
            state                  <= next_state;
            prdata                 <= next_prdata;
            err                    <= next_err;
            phase_offset_value     <= next_phase;
            group_period_broadcast <= next_bcast;
            drivers_0_to_2_period  <= next_periods;
            pwm_period_len         <= next_perlen;
            group_a_membership     <= next_grpa;
            group_b_membership     <= next_grpb;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // period timer
    logic period_tick;
    pwm_period_timer #(
        .PERIOD_CYCLES (PERIOD_CYCLES)
    ) u_timer (
        .pclk        (pclk),
        .presetn     (presetn),
        .period_len  (pwm_period_len),
        .period_tick (period_tick)
    );

    assign code_vec[0] = drivers_0_to_2_period.drv0;
    assign code_vec[1] = drivers_0_to_2_period.drv1;
    assign code_vec[2] = drivers_0_to_2_period.drv2;

    for (genvar i = 0; i < 3; i++) begin : g_pacer
        dim_update_pacer u_pacer (
            .pclk        (pclk),
            .presetn     (presetn),
            .period_tick (period_tick),
            .code        (code_vec[i]),
            .duty_update (duty_update[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_grp_write;
        wr_take && idx == `IDX_GROUP_BROADCAST;
    endsequence

    AST_RESET_VALUES: assert property (
        $rose(presetn) |-> phase_offset_value == 8'h13 && group_period_broadcast.sel == 2'h1
            && drivers_0_to_2_period == 9'h000)
        else $error("reset values wrong");

    AST_ZERO_SELECT: assert property (
        s_grp_write and pwdata[5:4] == 2'h0 |=>
            drivers_0_to_2_period == $past(drivers_0_to_2_period)
            && group_period_broadcast == $past(group_period_broadcast))
        else $error("zero select changed state");

    AST_GROUP_A_COPY: assert property (
        s_grp_write and pwdata[5:4] == 2'h1 and group_a_membership[0] |=>
            drivers_0_to_2_period.drv0 == $past(pwdata[2:0]))
        else $error("group a broadcast missed driver 0");

    AST_GROUP_B_COPY: assert property (
        s_grp_write and pwdata[5:4] == 2'h2 and group_b_membership[2]
            and !group_a_membership[2] |=>
            drivers_0_to_2_period.drv2 == $past(pwdata[2:0]))
        else $error("group b broadcast missed driver 2");

    AST_NON_MEMBER_KEPT: assert property (
        s_grp_write and pwdata[5:4] != 2'h0 and !members[1] |=>
            $stable(drivers_0_to_2_period.drv1))
        else $error("non member period changed");

    AST_COMBINED_READ: assert property (
        setup_cyc && !pwrite && idx == `IDX_DRIVERS_0_TO_2 ##1 penable |->
            prdata[10:8] == drivers_0_to_2_period.drv2 && prdata[6:4]
            == drivers_0_to_2_period.drv1 && prdata[2:0] == drivers_0_to_2_period.drv0)
        else $error("combined period read mismatch");

    AST_UPDATE_CODE0: assert property (
        period_tick && drivers_0_to_2_period.drv0 == 3'h0 |=> duty_update[0])
        else $error("code 0 must update every period");

    // unmapped index error
    AST_UNMAPPED_ERR: assert property (
        setup_cyc && !is_mapped(idx) ##1 penable |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not flagged");

    AST_PHASE_WRITE: assert property (
        wr_take && idx == `IDX_DRIVER5_PHASE |=> phase_offset_value == $past(pwdata[7:0]))
        else $error("phase offset write lost");

    AST_BOTH_GROUPS: assert property (
        s_grp_write and pwdata[5:4] == 2'h3
            and (group_a_membership[1] || group_b_membership[1])
            |=> drivers_0_to_2_period.drv1 == $past(pwdata[2:0]))
        else $error("two-group broadcast missed driver 1");

    AST_LEN_WRITE: assert property (
        wr_take && idx == `IDX_PWM_CFG |=> pwm_period_len == $past(pwdata[3:2]))
        else $error("period length write lost");

    AST_COMBINED_WRITE: assert property (
        wr_take && idx == `IDX_DRIVERS_0_TO_2 |=> drivers_0_to_2_period
            == {$past(pwdata[10:8]), $past(pwdata[6:4]), $past(pwdata[2:0])})
        else $error("combined period write lost");

    AST_UPDATE_NEEDS_TICK: assert property (
        !period_tick |=> duty_update == 3'h0)
        else $error("duty update without period tick");

    // access cycle follows setup
    AST_ACCESS_AFTER_SETUP: assert property (
        psel && penable |-> state == led_dim_pkg::ST_SETUP)
        else $error("access phase without setup");

endmodule // led_dim_period_phase_regs

`default_nettype wire

// file: verification/apb_host_model.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// apb master standing in for the host controller
module apb_host_model (
    // clock
    input  wire logic        pclk,
    // apb request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    // apb answer
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    int hangs;

    // idle bus at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
        hangs   = 0;
    end

    // one transfer; released address and write data are inverted so stale values never look valid
    task automatic xfer(input logic we, input logic [9:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= we;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 32);
        if (pready !== 1'b1) begin
            hangs++;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~{idx, 2'b00};
        pwdata  <= ~wd;
    endtask
endmodule // apb_host_model

`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "led_dim_params.svh"

////////////////////////////////////////////////////////////////////////////////
module tb;
    localparam int PER = 64;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        err;
    logic [7:0]  phase;
    logic [1:0]  plen;
    logic [2:0]  du;
    led_dim_pkg::period_set_t per;
    int          n_fail = 0;
    int          total_checks = 0;

    // clock
    always #5 pclk = ~pclk;

    led_dim_period_phase_regs #(.PERIOD_CYCLES(PER)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .phase_offset_value(phase),
        .drivers_0_to_2_period(per), .pwm_period_len(plen), .duty_update(du)
    );

    apb_host_model host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic conclude();
        n_fail += host.hangs;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one bus transfer; settle past the edge, a hung bus ends the run
    task automatic bus(input logic we, input logic [9:0] idx, input logic [31:0] d);
        host.xfer(we, idx, d, rdv, err);
        #1;
        if (host.hangs != 0) begin
            conclude();
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h00000000);
        chk(rdv, exp);
        chk({31'h00000000, err}, 32'h00000000);
    endtask

    // register image of the three packed period codes
    function automatic logic [31:0] img(input logic [8:0] p);
        return {21'h000000, p[8:6], 1'b0, p[5:3], 1'b0, p[2:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // reset values at ports and through the bus
    task automatic t_reset();
        chk({24'h000000, phase}, 32'h00000013);
        chk({23'h000000, per}, 32'h00000000);
        chk({30'h00000000, plen}, 32'h00000000);
        chk({29'h00000000, du}, 32'h00000000);
        rd(`IDX_DRIVER5_PHASE, 32'h00000013);
        rd(`IDX_GROUP_BROADCAST, 32'h00000010);
        rd(`IDX_DRIVERS_0_TO_2, 32'h00000000);
    endtask

    // phase offset and combined period fields read back independently
    task automatic t_fields();
        wr(`IDX_DRIVER5_PHASE, 32'h000000A5);
        rd(`IDX_DRIVER5_PHASE, 32'h000000A5);
        chk({24'h000000, phase}, 32'h000000A5);
        wr(`IDX_DRIVERS_0_TO_2, 32'h00000536);
        rd(`IDX_DRIVERS_0_TO_2, 32'h00000536);
        chk({23'h000000, per}, 32'h0000015E);
    endtask

    // broadcast to group a, b, both, and a dropped zero-select write
    task automatic t_group();
        logic [5:0] w [4] = '{6'h13, 6'h24, 6'h37, 6'h01};
        logic [8:0] e [4] = '{9'h0C3, 9'h0E3, 9'h1FF, 9'h1FF};
        int         k;
        wr(`IDX_GROUP_A_MEMBERS, 32'h00000005);
        wr(`IDX_GROUP_B_MEMBERS, 32'h00000002);
        wr(`IDX_DRIVERS_0_TO_2, 32'h00000000);
        for (k = 0; k < 4; k++) begin
            wr(`IDX_GROUP_BROADCAST, {26'h0000000, w[k]});
            chk({23'h000000, per}, {23'h000000, e[k]});
            rd(`IDX_DRIVERS_0_TO_2, img(e[k]));
            rd(`IDX_GROUP_BROADCAST, {26'h0000000, (k == 3) ? w[2] : w[k]});
        end
    endtask

    // unmapped index answers with an error and reads zero
    task automatic t_unmapped();
        bus(1'b0, 10'h3FF, 32'h00000000);
        chk({31'h00000000, err}, 32'h00000001);
        chk(rdv, 32'h00000000);
        bus(1'b1, 10'h3FF, 32'h000000FF);
        chk({31'h00000000, err}, 32'h00000001);
        rd(`IDX_DRIVER5_PHASE, 32'h000000A5);
    endtask

    // cycles between two update pulses of one driver, checked on the third
    task automatic measure(input int drv, input int exp);
        int c;
        int k;
        for (k = 0; k < 3; k++) begin
            c = 0;
            do begin
                @(posedge pclk);
                #1;
                c++;
            end while (du[drv] !== 1'b1 && c < 600);
            if (c >= 600) begin
                n_fail++;
                conclude();
            end
        end
        chk(32'(c), 32'(exp));
    endtask

    // every period code on a short period, then the period lengths
    task automatic t_pacing();
        int code;
        int l;
        wr(`IDX_PWM_CFG, 32'h0000000C);
        chk({30'h00000000, plen}, 32'h00000003);
        for (code = 0; code < 8; code++) begin
            wr(`IDX_DRIVERS_0_TO_2, 32'(code) << (4 * (code % 3)));
            measure(code % 3, (PER >> 3) * ((code > 5) ? 32 : (1 << code)));
        end
        wr(`IDX_DRIVERS_0_TO_2, 32'h00000000);
        for (l = 0; l < 3; l++) begin
            wr(`IDX_PWM_CFG, 32'(l) << 2);
            measure(0, PER >> l);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        t_reset();
        t_fields();
        t_group();
        t_unmapped();
        t_pacing();
        conclude();
    end
endmodule // tb

`default_nettype wire
